//--- ppdc_core.sv
// Playback path soft mute, widening, noise gate and dynamics control with AXI4-Lite registers
`default_nettype none
`include "ppdc_defines.svh"
// Behaviour
// - Mute ramp steps gain every 2 samples, or every 32 when slow selected.
// - Ramp steps count samples, so ramp time scales with sample rate.
// - Unmute without ramp select applies left and right volumes at once.
// - Unmute with ramp select raises gain one step at a time to volumes.
// - Depth code 0 is off; codes 1 to 31 give rising widening depth.
// - Widening acts only while its enable bit is set.
// - Gate activates only after signal stays quiet for the selected hold time.
// - Gate threshold is -60dB at code 0, 6dB lower per code.
// - Playback gate works only while enabled; disabled after reset.
// - RMS mode detects level above -30dB minus 1.5dB per code.
// - Peak mode detects crest factor above 12, 18, 24 or 30dB.
// - Mode bit picks crest criterion at 0, RMS at 1; resets to 1.
// - Signal detection runs only while enabled; off after reset.
// - Dynamics gate active only with its enable bit; off after reset.
// - Second knee output applied only when enabled; off after reset.
// - Quick release follows its bit, which resets to 1.
// - Anti-clip follows its bit, which resets to 1.
// - Three bits insert dynamics into playback, left record, right record.
// - Soft mute bit mutes when set and comes out of reset set.
// - Volume 0 mutes, codes from c0 up give 0dB.
module ppdc_core #(
    parameter logic [24:0] HOLD0_CYC = 25'(`PPDC_NG_HOLD0_MS * (`PPDC_CLK_HZ / 1000)),
    parameter logic [24:0] HOLD1_CYC = 25'(`PPDC_NG_HOLD1_MS * (`PPDC_CLK_HZ / 1000)),
    parameter logic [24:0] HOLD2_CYC = 25'(`PPDC_NG_HOLD2_MS * (`PPDC_CLK_HZ / 1000)),
    parameter logic [24:0] HOLD3_CYC = 25'(`PPDC_NG_HOLD3_MS * (`PPDC_CLK_HZ / 1000))
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic smp_valid,
    input wire ppdc_pkg::ppdc_smp_t smp_left,
    input wire ppdc_pkg::ppdc_smp_t smp_right,
    output logic out_valid,
    output ppdc_pkg::ppdc_smp_t out_left,
    output ppdc_pkg::ppdc_smp_t out_right,
    output ppdc_pkg::ppdc_gain_t gain_left,
    output ppdc_pkg::ppdc_gain_t gain_right,
    output logic [4:0] widen_depth,
    output logic widen_active,
    output logic gate_active,
    output logic detect_flag,
    output logic dyn_gate_en,
    output logic second_knee_en,
    output logic quick_release_en,
    output logic anti_clip_en,
    output logic [2:0] dyn_path
);
    import ppdc_pkg::*;

    localparam ppdc_st_t ST_RST = '{
        awready: 1'b1, wready: 1'b1, arready: 1'b1,
        f1: `PPDC_RST_F1, f2: `PPDC_RST_F2, ng: `PPDC_RST_NG, dynamics_processor: `PPDC_RST_DRC,
        vol_l: `PPDC_RST_VOL, vol_r: `PPDC_RST_VOL, act_l: `PPDC_RST_VOL, act_r: `PPDC_RST_VOL,
        sh_ng: `PPDC_RST_NG, dyn_flags: 4'h3, default: '0};

    ppdc_st_t st;
    ppdc_st_t n;
    logic step_tick;
    logic [23:0] abs_l;
    logic [23:0] abs_r;
    logic [23:0] pk;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [15:0] wr16(input logic [15:0] old, input logic [15:0] d,
                                         input logic [1:0] s, input logic [15:0] m);
        logic [15:0] v;
        v = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
        return v & m;
    endfunction : wr16

    function automatic logic [23:0] mag(input logic [23:0] x);
        return x[23] ? 24'(-x) : x;
    endfunction : mag

    // Volume codes from c0 up all mean 0dB
    function automatic logic [7:0] clampv(input logic [7:0] v);
        return (v >= `PPDC_VOL_MAX) ? `PPDC_VOL_MAX : v;
    endfunction : clampv

    function automatic logic [7:0] ramp(input logic [7:0] cur, input logic [7:0] vol,
                                        input logic mute, input logic rsel, input logic tick);
        logic [7:0] t;
        t = clampv(vol);
        if (mute)
        begin
            ramp = (tick && cur != 8'h00) ? 8'(cur - 8'h01) : cur;
        end
        else if (!rsel)
        begin
            ramp = t;
        end
        else if (cur < t)
        begin
            ramp = tick ? 8'(cur + 8'h01) : cur;
        end
        else
        begin
            ramp = t;
        end
    endfunction : ramp

    // -30dB less 1.5dB per code: 6dB per four codes, quarter steps by table
    function automatic logic [23:0] rms_thr(input logic [4:0] c);
        logic [23:0] b;
        logic [8:0] f;
        logic [32:0] p;
        b = `PPDC_RMS_BASE >> c[4:2];
        unique case (c[1:0])
            2'h0: f = 9'h100;
            2'h1: f = 9'h0d7;
            2'h2: f = 9'h0b5;
            2'h3: f = 9'h099;
        endcase
        p = 33'(b) * 33'(f);
        return p[31:8];
    endfunction : rms_thr

    function automatic logic [24:0] hold_sel(input logic [1:0] c);
        unique case (c)
            2'h0: hold_sel = HOLD0_CYC;
            2'h1: hold_sel = HOLD1_CYC;
            2'h2: hold_sel = HOLD2_CYC;
            2'h3: hold_sel = HOLD3_CYC;
        endcase
    endfunction : hold_sel

    function automatic logic [31:0] rd(input ppdc_st_t s, input logic [13:0] i);
        unique case (i)
            `PPDC_IDX_F1: rd = {16'h0000, s.f1};
            `PPDC_IDX_F2: rd = {16'h0000, s.f2};
            `PPDC_IDX_NG: rd = {16'h0000, s.ng};
            `PPDC_IDX_DRC: rd = {16'h0000, s.dynamics_processor};
            `PPDC_IDX_VOLL: rd = {24'h000000, s.vol_l};
            `PPDC_IDX_VOLR: rd = {24'h000000, s.vol_r};
            `PPDC_IDX_STAT: rd = {14'h0000, s.detect, s.gate_act, s.gain_r, s.gain_l};
            default: rd = 32'h00000000;
        endcase
    endfunction : rd

    function automatic logic mapped(input logic [13:0] i);
        return i == `PPDC_IDX_F1 || i == `PPDC_IDX_F2 || i == `PPDC_IDX_NG || i == `PPDC_IDX_DRC
            || i == `PPDC_IDX_VOLL || i == `PPDC_IDX_VOLR || i == `PPDC_IDX_STAT;
    endfunction : mapped

    ////////////////////////////////////////////////////////////////////////
    // Next state

    assign abs_l = mag(smp_left);
    assign abs_r = mag(smp_right);
    assign pk = (abs_l > abs_r) ? abs_l : abs_r;
    assign step_tick = smp_valid && (st.scnt == (st.f1[`PPDC_RATE_BIT] ? `PPDC_SLOW_DIV
                                                                        : `PPDC_FAST_DIV));

    always_comb
    begin
        n = st;
        // Write address and data taken in either order
        if (s_axi_awvalid && st.awready)
        begin
            n.aw_have = 1'b1;
            n.aw_idx = s_axi_awaddr[15:2];
            n.awready = 1'b0;
        end
        if (s_axi_wvalid && st.wready)
        begin
            n.w_have = 1'b1;
            n.wdata = s_axi_wdata[15:0];
            n.wstrb = s_axi_wstrb[1:0];
            n.wready = 1'b0;
        end
        if (st.bvalid && s_axi_bready)
        begin
            n.bvalid = 1'b0;
            n.awready = 1'b1;
            n.wready = 1'b1;
        end
        if (st.aw_have && st.w_have && !st.bvalid)
        begin
            n.aw_have = 1'b0;
            n.w_have = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = mapped(st.aw_idx) ? `PPDC_RESP_OK : `PPDC_RESP_ERR;
            unique case (st.aw_idx)
                `PPDC_IDX_F1: n.f1 = wr16(st.f1, st.wdata, st.wstrb, `PPDC_MASK_F1);
                `PPDC_IDX_F2: n.f2 = wr16(st.f2, st.wdata, st.wstrb, `PPDC_MASK_F2);
                `PPDC_IDX_NG: n.ng = wr16(st.ng, st.wdata, st.wstrb, `PPDC_MASK_NG);
                `PPDC_IDX_DRC: n.dynamics_processor = wr16(st.dynamics_processor, st.wdata, st.wstrb, `PPDC_MASK_DRC);
                `PPDC_IDX_VOLL: n.vol_l = st.wstrb[0] ? st.wdata[7:0] : st.vol_l;
                `PPDC_IDX_VOLR: n.vol_r = st.wstrb[0] ? st.wdata[7:0] : st.vol_r;
                default: n.bresp = mapped(st.aw_idx) ? `PPDC_RESP_OK : `PPDC_RESP_ERR;
            endcase
            // Volume update bit moves both pending volumes at once
            if ((st.aw_idx == `PPDC_IDX_VOLL || st.aw_idx == `PPDC_IDX_VOLR)
                && st.wstrb[1] && st.wdata[`PPDC_VU_BIT])
            begin
                n.act_l = n.vol_l;
                n.act_r = n.vol_r;
            end
        end
        // Read answers one cycle after the address is taken
        if (st.rvalid && s_axi_rready)
        begin
            n.rvalid = 1'b0;
            n.arready = 1'b1;
        end
        if (s_axi_arvalid && st.arready)
        begin
            n.arready = 1'b0;
            n.rvalid = 1'b1;
            n.rdata = rd(st, s_axi_araddr[15:2]);
            n.rresp = mapped(s_axi_araddr[15:2]) ? `PPDC_RESP_OK : `PPDC_RESP_ERR;
        end

        // Sample boundary: configuration latched and gains stepped
        n.ovalid = smp_valid;
        if (smp_valid)
        begin
            n.scnt = step_tick ? 5'h00 : 5'(st.scnt + 5'h01);
            n.gain_l = ramp(st.gain_l, st.act_l, st.f1[`PPDC_MUTE_BIT], st.f1[`PPDC_URAMP_BIT], step_tick);
            n.gain_r = ramp(st.gain_r, st.act_r, st.f1[`PPDC_MUTE_BIT], st.f1[`PPDC_URAMP_BIT], step_tick);
            n.sh_ng = st.ng;
            n.widen = st.f2[`PPDC_WEN_BIT] ? st.f2[`PPDC_WID_HI:`PPDC_WID_LO] : 5'h00;
            n.widen_act = st.f2[`PPDC_WEN_BIT] && st.f2[`PPDC_WID_HI:`PPDC_WID_LO] != 5'h00;
            n.dyn_flags = {st.dynamics_processor[`PPDC_DNG_BIT], st.dynamics_processor[`PPDC_KNEE_BIT],
                           st.dynamics_processor[`PPDC_QR_BIT], st.dynamics_processor[`PPDC_AC_BIT]};
            n.dyn_path = st.dynamics_processor[2:0];
            n.quiet = pk < (`PPDC_NG_THR_BASE >> st.ng[`PPDC_NGT_HI:`PPDC_NGT_LO]);
            if (st.dynamics_processor[`PPDC_DET_BIT])
            begin
                n.avg = 24'(st.avg + (pk >> 6) - (st.avg >> 6));
                if (st.dynamics_processor[`PPDC_DMODE_BIT])
                begin
                    n.detect = st.avg >= rms_thr(st.dynamics_processor[`PPDC_RMS_HI:`PPDC_RMS_LO]);
                end
                else
                begin
                    n.detect = 29'(pk) >= (29'(st.avg) << (3'h2 + 3'(st.dynamics_processor[`PPDC_PK_HI:`PPDC_PK_LO])));
                end
            end
            else
            begin
                n.detect = 1'b0;
            end
            n.oleft = (st.gate_act || st.gain_l == 8'h00) ? 24'h000000 : smp_left;
            n.oright = (st.gate_act || st.gain_r == 8'h00) ? 24'h000000 : smp_right;
        end

        // Playback gate hold timer runs on the clock
        if (!n.sh_ng[`PPDC_NGE_BIT] || !n.quiet)
        begin
            n.hold_cnt = 25'h0000000;
            n.gate_act = 1'b0;
        end
        else if (st.hold_cnt >= hold_sel(st.sh_ng[`PPDC_NGH_HI:`PPDC_NGH_LO]))
        begin
            n.gate_act = 1'b1;
        end
        else
        begin
            n.hold_cnt = 25'(st.hold_cnt + 25'h0000001);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st <= ST_RST;
        end
        else
        begin
            st <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bresp = st.bresp;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_arready = st.arready;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rvalid = st.rvalid;
    assign out_valid = st.ovalid;
    assign out_left = st.oleft;
    assign out_right = st.oright;
    assign gain_left = st.gain_l;
    assign gain_right = st.gain_r;
    assign widen_depth = st.widen;
    assign widen_active = st.widen_act;
    assign gate_active = st.gate_act;
    assign detect_flag = st.detect;
    assign dyn_gate_en = st.dyn_flags[3];
    assign second_knee_en = st.dyn_flags[2];
    assign quick_release_en = st.dyn_flags[1];
    assign anti_clip_en = st.dyn_flags[0];
    assign dyn_path = st.dyn_path;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_mute_no_rise: assert property (smp_valid && st.f1[`PPDC_MUTE_BIT] |=>
        st.gain_l <= $past(st.gain_l)) else $error("gain rose while muted");
    a_mute_one_step: assert property (smp_valid && st.f1[`PPDC_MUTE_BIT] |=>
        9'(st.gain_l) + 9'h001 >= 9'($past(st.gain_l))) else $error("mute step above one");
    a_ramp_tick_only: assert property (smp_valid && !step_tick |=>
        st.gain_l == $past(st.gain_l) || !$past(st.f1[`PPDC_MUTE_BIT])) else $error("step off tick");
    a_unmute_jump: assert property (smp_valid && !st.f1[`PPDC_MUTE_BIT] && !st.f1[`PPDC_URAMP_BIT] |=>
        st.gain_l == clampv($past(st.act_l))) else $error("unmute not immediate");
    a_unmute_ramp: assert property (smp_valid && !st.f1[`PPDC_MUTE_BIT] && st.f1[`PPDC_URAMP_BIT] |=>
        9'(st.gain_r) <= 9'($past(st.gain_r)) + 9'h001) else $error("unmute ramp too steep");
    a_widen_off: assert property (smp_valid && !st.f2[`PPDC_WEN_BIT] |=>
        st.widen == 5'h00 && !st.widen_act) else $error("widening while disabled");
    a_gate_off: assert property (!st.sh_ng[`PPDC_NGE_BIT] |-> !st.gate_act)
        else $error("gate active while disabled");
    a_detect_off: assert property (smp_valid && !st.dynamics_processor[`PPDC_DET_BIT] |=> !st.detect)
        else $error("detect while disabled");
    a_dyn_path: assert property (smp_valid |=> st.dyn_path == $past(st.dynamics_processor[2:0]))
        else $error("dynamics path not latched");
    a_unmute_jump_r: assert property (smp_valid && !st.f1[`PPDC_MUTE_BIT] && !st.f1[`PPDC_URAMP_BIT] |=>
        st.gain_r == clampv($past(st.act_r))) else $error("right unmute not immediate");
    a_mute_no_rise_r: assert property (smp_valid && st.f1[`PPDC_MUTE_BIT] |=>
        st.gain_r <= $past(st.gain_r)) else $error("right gain rose while muted");
    a_gain_cap: assert property (st.gain_l <= `PPDC_VOL_MAX && st.gain_r <= `PPDC_VOL_MAX)
        else $error("gain above full scale code");
    a_widen_depth: assert property (smp_valid && st.f2[`PPDC_WEN_BIT] |=>
        st.widen == $past(st.f2[`PPDC_WID_HI:`PPDC_WID_LO])) else $error("depth not latched");
    a_gate_hold: assert property ($rose(st.gate_act) |-> st.hold_cnt >= HOLD0_CYC)
        else $error("gate closed before hold time");
    a_gate_quiet: assert property (st.gate_act |-> st.quiet)
        else $error("gate closed on loud signal");
    a_gate_mutes: assert property (smp_valid && st.gate_act |=> st.oleft == 24'h000000)
        else $error("sample passed closed gate");
    a_dyn_flags: assert property (smp_valid |=>
        st.dyn_flags[1] == $past(st.dynamics_processor[`PPDC_QR_BIT]) && st.dyn_flags[0] == $past(st.dynamics_processor[`PPDC_AC_BIT]))
        else $error("dynamics flags not latched");

    c_mute_done: cover property (st.f1[`PPDC_MUTE_BIT] && $fell(st.gain_l != 8'h00));
    c_gate_on: cover property ($rose(st.gate_act));
    c_detect_on: cover property ($rose(st.detect));
    c_ramp_up: cover property (!st.f1[`PPDC_MUTE_BIT] && st.f1[`PPDC_URAMP_BIT] && st.gain_l > $past(st.gain_l));
endmodule : ppdc_core
`default_nettype wire

//--- ppdc_core_tb.sv
// Self-checking bench for the playback path and dynamics control block
`default_nettype none
module ppdc_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ppdc_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [15:0] s_axi_awaddr = '0;
    logic [15:0] s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [2:0] s_axi_awprot = '0;
    logic [2:0] s_axi_arprot = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp;
    logic [1:0] s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic smp_valid, out_valid, widen_active, gate_active, detect_flag;
    logic dyn_gate_en, second_knee_en, quick_release_en, anti_clip_en;
    ppdc_smp_t smp_left, smp_right, out_left, out_right;
    ppdc_gain_t gain_left, gain_right;
    logic [4:0] widen_depth;
    logic [2:0] dyn_path;
    logic [31:0] rd_data;
    logic [1:0] rd_resp;
    logic [15:0] wcfg [4] = '{16'h3e00, 16'h3f00, 16'h0100, 16'h0300};
    logic [4:0] wexp [4] = '{5'h00, 5'h1f, 5'h00, 5'h01};
    int bad_count = 0;
    int checks_done = 0;
    int cyc = 0;
    ppdc_core #(
        .HOLD0_CYC(25'd20),
        .HOLD1_CYC(25'd40),
        .HOLD2_CYC(25'd60),
        .HOLD3_CYC(25'd80)
    ) i_ppdc_core (
        .aclk,
        .aresetn,
        .s_axi_awaddr,
        .s_axi_awprot,
        .s_axi_awvalid,
        .s_axi_awready,
        .s_axi_wdata,
        .s_axi_wstrb,
        .s_axi_wvalid,
        .s_axi_wready,
        .s_axi_bresp,
        .s_axi_bvalid,
        .s_axi_bready,
        .s_axi_araddr,
        .s_axi_arprot,
        .s_axi_arvalid,
        .s_axi_arready,
        .s_axi_rdata,
        .s_axi_rresp,
        .s_axi_rvalid,
        .s_axi_rready,
        .smp_valid,
        .smp_left,
        .smp_right,
        .out_valid,
        .out_left,
        .out_right,
        .gain_left,
        .gain_right,
        .widen_depth,
        .widen_active,
        .gate_active,
        .detect_flag,
        .dyn_gate_en,
        .second_knee_en,
        .quick_release_en,
        .anti_clip_en,
        .dyn_path
    );
    ppdc_src_model i_ppdc_src_model (
        .aclk,
        .smp_valid,
        .smp_left,
        .smp_right
    );
    ////////////////////////////////////////////////////////////////////////
    always #10 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            bad_count++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("Checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic rdc(input logic [15:0] a, input logic [31:0] e);
        rd(a);
        chk("rdata", e, rd_data);
    endtask : rdc
    task automatic smp(input ppdc_smp_t v, input int n, input int gap);
        repeat (n) i_ppdc_src_model.send(v, v, gap);
        #1;
    endtask : smp
    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask : wt
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        chk("qr", 32'h1, quick_release_en);
        chk("ac", 32'h1, anti_clip_en);
        rdc(16'h1480, 32'h0200);
        rdc(16'h1484, 32'h0000);
        rdc(16'h14c0, 32'h0068);
        rdc(16'h1500, 32'h0098);
        rdc(16'h1408, 32'h00c0);
        rd(16'h1000);
        chk("rresp", 32'h2, rd_resp);
        wr(16'h1480, 32'hffff, 4'hf);
        rdc(16'h1480, 32'h02b0);
        smp(24'h123456, 1, 0);
        chk("gain", 32'h0, gain_left);
        chk("out", 32'h0, out_left);
        wr(16'h1480, 32'h0, 4'h3);
        smp(24'h123456, 2, 0);
        chk("gain", 32'hc0, gain_left);
        chk("gainr", 32'hc0, gain_right);
        chk("valid", 32'h1, out_valid);
        chk("out", 32'h123456, out_left);
        chk("outr", 32'h123456, out_right);
        wr(16'h140c, 32'h0, 4'h1);
        wr(16'h1408, 32'h100, 4'h3);
        smp(24'h123456, 2, 0);
        chk("out", 32'h0, out_left);
        chk("outr", 32'h0, out_right);
        chk("gainr", 32'h0, gain_right);
        wr(16'h140c, 32'h8, 4'h1);
        wr(16'h1408, 32'h108, 4'h3);
        smp(24'h000100, 1, 0);
        chk("gain", 32'h8, gain_left);
        wr(16'h1480, 32'h0200, 4'h3);
        smp(24'h000100, 14, 3);
        chk("gain", 32'h1, gain_left != 0);
        smp(24'h000100, 2, 3);
        chk("gain", 32'h0, gain_left);
        wr(16'h1480, 32'h0010, 4'h3);
        smp(24'h000100, 4, 0);
        chk("gain", 32'h1, gain_left != 0 && gain_left < 8);
        smp(24'h000100, 14, 0);
        chk("gain", 32'h8, gain_left);
        wr(16'h1480, 32'h0220, 4'h3);
        smp(24'h000100, 224, 0);
        chk("gain", 32'h1, gain_left != 0);
        smp(24'h000100, 32, 0);
        chk("gain", 32'h0, gain_left);
        wr(16'h1480, 32'h0, 4'h3);
        for (int i = 0; i < 4; i++)
        begin
            wr(16'h1484, 32'(wcfg[i]), 4'h3);
            smp(24'h000100, 1, 0);
            chk("depth", 32'(wexp[i]), widen_depth);
            chk("widen", 32'(wexp[i] != 0), widen_active);
        end
        for (int h = 0; h < 4; h++)
        begin
            wr(16'h14c0, 32'(h * 32 + 1), 4'h3);
            smp(24'h000100, 1, 0);
            wt(20 * h + 17);
            chk("gate", 32'h0, gate_active);
            wt(6);
            chk("gate", 32'h1, gate_active);
            smp(24'h000100, 1, 0);
            chk("out", 32'h0, out_left);
            smp(24'h100000, 2, 0);
            chk("gate", 32'h0, gate_active);
            chk("out", 32'h100000, out_left);
        end
        wr(16'h14c0, 32'h0f, 4'h3);
        smp(24'h000050, 1, 0);
        wt(30);
        chk("gate", 32'h0, gate_active);
        smp(24'h000030, 1, 0);
        wt(30);
        chk("gate", 32'h1, gate_active);
        wr(16'h14c0, 32'h0e, 4'h3);
        smp(24'h000030, 1, 0);
        wt(30);
        chk("gate", 32'h0, gate_active);
        wr(16'h1500, 32'h0127, 4'h3);
        chk("path", 32'h0, dyn_path);
        smp(24'h000100, 1, 0);
        chk("dgate", 32'h1, dyn_gate_en);
        chk("knee", 32'h1, second_knee_en);
        chk("qr", 32'h0, quick_release_en);
        chk("ac", 32'h0, anti_clip_en);
        for (int p = 0; p < 3; p++)
        begin
            wr(16'h1500, 32'h18 | (32'h1 << p), 4'h3);
            smp(24'h000100, 1, 0);
            chk("path", 32'h1 << p, dyn_path);
            chk("qr", 32'h1, quick_release_en);
        end
        chk("dgate", 32'h0, dyn_gate_en);
        chk("knee", 32'h0, second_knee_en);
        chk("ac", 32'h1, anti_clip_en);
        wr(16'h1500, 32'h00d8, 4'h3);
        smp(24'h7fffff, 10, 0);
        chk("detect", 32'h1, detect_flag);
        for (int c = 0; c < 4; c++)
        begin
            wr(16'h1500, 32'h0058 | 32'(c << 9), 4'h3);
            smp(24'h000010, 1, 0);
            chk("detect", 32'h0, detect_flag);
        end
        wr(16'h1500, 32'h00d8, 4'h3);
        smp(24'h000010, 1, 0);
        chk("detect", 32'h1, detect_flag);
        wr(16'h1500, 32'h0098, 4'h3);
        smp(24'h7fffff, 1, 0);
        chk("detect", 32'h0, detect_flag);
        complete_run();
    end
endmodule : ppdc_core_tb
`default_nettype wire

//--- ppdc_defines.svh
// Register map, field positions, reset values and timing counts
`ifndef PPDC_DEFINES_SVH
`define PPDC_DEFINES_SVH
`define PPDC_IDX_F1 14'h0520
`define PPDC_IDX_F2 14'h0521
`define PPDC_IDX_NG 14'h0530
`define PPDC_IDX_DRC 14'h0540
`define PPDC_IDX_VOLL 14'h0502
`define PPDC_IDX_VOLR 14'h0503
`define PPDC_IDX_STAT 14'h05f0
`define PPDC_MASK_F1 16'h02b0
`define PPDC_MASK_F2 16'h3f00
`define PPDC_MASK_NG 16'h006f
`define PPDC_MASK_DRC 16'hffff
`define PPDC_RST_F1 16'h0200
`define PPDC_RST_F2 16'h0000
`define PPDC_RST_NG 16'h0068
`define PPDC_RST_DRC 16'h0098
`define PPDC_RST_VOL 8'hc0
`define PPDC_VOL_MAX 8'hc0
`define PPDC_VU_BIT 8
`define PPDC_MUTE_BIT 9
`define PPDC_RATE_BIT 5
`define PPDC_URAMP_BIT 4
`define PPDC_WID_HI 13
`define PPDC_WID_LO 9
`define PPDC_WEN_BIT 8
`define PPDC_NGH_HI 6
`define PPDC_NGH_LO 5
`define PPDC_NGT_HI 3
`define PPDC_NGT_LO 1
`define PPDC_NGE_BIT 0
`define PPDC_RMS_HI 15
`define PPDC_RMS_LO 11
`define PPDC_PK_HI 10
`define PPDC_PK_LO 9
`define PPDC_DNG_BIT 8
`define PPDC_DMODE_BIT 7
`define PPDC_DET_BIT 6
`define PPDC_KNEE_BIT 5
`define PPDC_QR_BIT 4
`define PPDC_AC_BIT 3
`define PPDC_FAST_DIV 5'h01
`define PPDC_SLOW_DIV 5'h1f
`define PPDC_NG_THR_BASE 24'h0020c4
`define PPDC_RMS_BASE 24'h040c37
`define PPDC_CLK_HZ 50000000
`define PPDC_NG_HOLD0_MS 30
`define PPDC_NG_HOLD1_MS 125
`define PPDC_NG_HOLD2_MS 250
`define PPDC_NG_HOLD3_MS 500
`define PPDC_RESP_OK 2'h0
`define PPDC_RESP_ERR 2'h2
`endif

//--- ppdc_pkg.sv
// Types of the playback path and dynamics control block
`default_nettype none
`include "ppdc_defines.svh"
package ppdc_pkg;
    typedef logic [23:0] ppdc_smp_t;
    typedef logic [7:0] ppdc_gain_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_have;
        logic [13:0] aw_idx;
        logic w_have;
        logic [15:0] wdata;
        logic [1:0] wstrb;
        logic [15:0] f1;
        logic [15:0] f2;
        logic [15:0] ng;
        logic [15:0] dynamics_processor;
        logic [7:0] vol_l;
        logic [7:0] vol_r;
        logic [7:0] act_l;
        logic [7:0] act_r;
        logic [15:0] sh_ng;
        logic [7:0] gain_l;
        logic [7:0] gain_r;
        logic [4:0] scnt;
        logic [24:0] hold_cnt;
        logic quiet;
        logic gate_act;
        logic [23:0] avg;
        logic detect;
        logic [4:0] widen;
        logic widen_act;
        logic [3:0] dyn_flags;
        logic [2:0] dyn_path;
        logic ovalid;
        logic [23:0] oleft;
        logic [23:0] oright;
    } ppdc_st_t;
endpackage : ppdc_pkg
`default_nettype wire

//--- ppdc_src_model.sv
// Sample source standing in for the processor on the audio interface
`default_nettype none
module ppdc_src_model (
    input wire logic aclk,
    output logic smp_valid,
    output ppdc_pkg::ppdc_smp_t smp_left,
    output ppdc_pkg::ppdc_smp_t smp_right
);
    import ppdc_pkg::*;
    initial
    begin
        smp_valid = 1'b0;
        smp_left = '0;
        smp_right = '0;
    end
    // One sample per call, then gap idle cycles; data inverted once released
    task automatic send(input ppdc_smp_t l, input ppdc_smp_t r, input int gap);
        @(posedge aclk);
        smp_valid <= 1'b1;
        smp_left <= l;
        smp_right <= r;
        @(posedge aclk);
        smp_valid <= 1'b0;
        smp_left <= ~l;
        smp_right <= ~r;
        repeat (gap) @(posedge aclk);
    endtask : send
endmodule : ppdc_src_model
`default_nettype wire
